// ### design/rfr_map.svh
`ifndef RFR_MAP_SVH
`define RFR_MAP_SVH

// Register indices; byte address is four times the index
`define RFR_IDX_BASE 10'h0e0
`define RFR_IDX_INTV 10'h0e2
`define RFR_IDX_ENCNT 10'h0e4
`define RFR_ADR(idx) ({(idx), 2'b00})

// Field positions
`define RFR_EN_BIT 15

// Reset values
`define RFR_BASE_RST 7'h00
`define RFR_INTV_RST 9'h000
`define RFR_CNT_RST 9'h000
`define RFR_ROW_RST 9'h000

// Lowest interval that leaves time for one refresh cycle
`define RFR_INTV_MIN 9'h012
// Counter value whose step lands on one
`define RFR_CNT_HIT 9'h002

// Status line codes
`define RFR_STAT_MEMRD 3'h5
`define RFR_STAT_IDLE 3'h7

// Clock period in ns
`define RFR_CLK_NS 40

`endif

// ### design/rfr_pkg.sv
package rfr_pkg;

  typedef enum logic [1:0] {
    RFR_IDLE = 2'b00,
    RFR_ADDR = 2'b01,
    RFR_DATA = 2'b11,
    RFR_DONE = 2'b10
  } rfr_state_t;

  typedef struct packed {
    logic active;
    logic [19:0] addr;
    logic [2:0] status;
    logic rd_n;
    logic byte_high_enable_n;
  } rfr_cyc_t;

endpackage

// ### design/rfr_prio_arb.sv
`timescale 1ns/1ps
module rfr_prio_arb #(
  parameter int N = 4
) (
  // Requests, bit 0 highest priority
  input wire logic [N-1:0] i_req,
  // One-hot grant
  output logic [N-1:0] o_grant
);

  if (N < 2) begin : g_bad
    $error("rfr_prio_arb: N must be at least 2");
  end

  wire logic [N-1:0] req_less_one;

  assign req_less_one = i_req - N'(1);
  assign o_grant = i_req & ~req_less_one;

endmodule

// ### design/rfr_refresh_unit.sv
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "rfr_map.svh"
// How it works
// - Interval counter steps down on every clock edge with i_ce high, whatever the bus does.
// - Stepping to one raises a request and reloads from the interval.
// - Upper seven address bits come from the base register, 8 KB granule.
// - Row counter wrap never carries into the base register.
// - 20-bit address: base, fixed zeros, 9-bit row counter, fixed one.
// - Pending refresh wins the bus over CPU, DMA and hold requests.
// - Refresh runs as a dummy memory read once the bus is free.
// - Register reads and writes are ignored outside enhanced mode.
// - Only one request is held; a newer one while pending is dropped.
// - Row address advances only when a refresh cycle actually ran.
// - Unit drives status and strobes; outside controller makes RAS/CAS.
// - Setting enable loads the counter; clearing stops and clears it.
// - Reads give enable and live count; writes while running keep count.
// - Request stays until serviced; service clears it, increments row.
// - Address bit 0 high; byte-high pin high on wide, low on narrow bus.
module rfr_refresh_unit #(
  parameter int CNT_W = 9,
  parameter int ROW_W = 9,
  parameter bit WIDE_BUS = 1'b1
) (
  // Clock, reset, clock enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Processor mode
  input wire logic i_enhanced_mode,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // Bus arbitration
  input wire logic i_cpu_req,
  input wire logic i_dma_req,
  input wire logic i_hold_req,
  input wire logic i_bus_busy,
  output logic [3:0] o_grant,
  // Memory interface
  input wire logic i_mem_ready,
  output rfr_pkg::rfr_cyc_t o_cyc,
  output logic o_refresh_req,
  output logic o_req_lost
);

  localparam int BASE_W = 7;
  localparam int ZW = 19 - BASE_W - ROW_W;

  if (CNT_W < 5 || CNT_W > 12 || ROW_W < 1 || ROW_W > 9) begin : g_bad
    $error("rfr_refresh_unit: unsupported width parameters");
  end

  // Registers
  logic ack_q;
  logic [31:0] dat_q;
  logic [BASE_W-1:0] base_q;
  logic [CNT_W-1:0] intv_q;
  logic en_q;
  logic [CNT_W-1:0] cnt_q;
  logic [ROW_W-1:0] row_q;
  logic req_q;
  logic lost_q;
  rfr_pkg::rfr_state_t st_q;
  rfr_pkg::rfr_state_t st_d;
  rfr_pkg::rfr_cyc_t cyc_q;
  rfr_pkg::rfr_cyc_t cyc_d;

  // Bus decode
  wire logic bus_req = i_wb_cyc & i_wb_stb;
  wire logic ack_d = bus_req & ~ack_q;
  wire logic hit_base = i_wb_adr == `RFR_ADR(`RFR_IDX_BASE);
  wire logic hit_intv = i_wb_adr == `RFR_ADR(`RFR_IDX_INTV);
  wire logic hit_en = i_wb_adr == `RFR_ADR(`RFR_IDX_ENCNT);
  wire logic wr_take = bus_req & i_wb_we & ack_q & i_enhanced_mode;
  wire logic wr_base = wr_take & hit_base & i_wb_sel[1];
  wire logic wr_intv = wr_take & hit_intv & (|i_wb_sel[1:0]);
  wire logic wr_en = wr_take & hit_en & i_wb_sel[1];
  wire logic [15:0] lane_mask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire logic [CNT_W-1:0] intv_mask = lane_mask[CNT_W-1:0];
  wire logic [CNT_W-1:0] intv_d =
    (intv_q & ~intv_mask) | (i_wb_dat[CNT_W-1:0] & intv_mask);

  // Read path
  wire logic [15:0] rd_base = {base_q, {(16 - BASE_W){1'b0}}};
  wire logic [15:0] rd_intv = {{(16 - CNT_W){1'b0}}, intv_q};
  wire logic [15:0] rd_en = {en_q, {(15 - CNT_W){1'b0}}, cnt_q};
  wire logic [15:0] rd_sel =
    hit_base ? rd_base :
    hit_intv ? rd_intv :
    hit_en ? rd_en : 16'h0000;
  wire logic [15:0] rd_word = i_enhanced_mode ? rd_sel : 16'h0000;

  // Interval counter
  wire logic en_set = wr_en & i_wb_dat[`RFR_EN_BIT];
  wire logic en_clr = wr_en & ~i_wb_dat[`RFR_EN_BIT];
  wire logic en_rise = en_set & ~en_q;
  // A count at or below the hit value also reloads, so a bad interval
  // cannot wrap the counter past zero to its top value
  wire logic tick = en_q & (cnt_q <= CNT_W'(`RFR_CNT_HIT));
  wire logic [CNT_W-1:0] cnt_d =
    en_clr ? CNT_W'(`RFR_CNT_RST) :
    en_rise ? intv_q :
    !en_q ? CNT_W'(`RFR_CNT_RST) :
    tick ? intv_q :
    cnt_q - CNT_W'(1);

  // Request and bus cycle
  wire logic served = st_q == rfr_pkg::RFR_DONE;
  wire logic req_d = tick | (req_q & ~served);
  wire logic bus_free = ~i_bus_busy & (st_q == rfr_pkg::RFR_IDLE);
  wire logic [3:0] arb_req =
    {i_cpu_req, i_dma_req, i_hold_req, req_q} & {4{bus_free}};
  wire logic start = o_grant[0];
  wire logic [19:0] rfr_addr =
    {base_q, {ZW{1'b0}}, row_q, 1'b1};

  rfr_prio_arb #(
    .N(4)
  ) u_arb (
    .i_req(arb_req),
    .o_grant(o_grant)
  );

  always_comb begin
    case (st_q)
      rfr_pkg::RFR_IDLE: st_d = start ? rfr_pkg::RFR_ADDR : rfr_pkg::RFR_IDLE;
      rfr_pkg::RFR_ADDR: st_d = rfr_pkg::RFR_DATA;
      rfr_pkg::RFR_DATA: st_d = i_mem_ready ? rfr_pkg::RFR_DONE :
                                              rfr_pkg::RFR_DATA;
      rfr_pkg::RFR_DONE: st_d = rfr_pkg::RFR_IDLE;
      default: st_d = rfr_pkg::RFR_IDLE;
    endcase
  end

  // Looks to memory like any read: same status code and strobes
  always_comb begin
    cyc_d.active = st_d != rfr_pkg::RFR_IDLE;
    cyc_d.addr = rfr_addr;
    cyc_d.status = cyc_d.active ? `RFR_STAT_MEMRD : `RFR_STAT_IDLE;
    cyc_d.rd_n = st_d != rfr_pkg::RFR_DATA;
    cyc_d.byte_high_enable_n = cyc_d.active ? WIDE_BUS : 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (i_ce) begin
      ack_q <= ack_d;
      if (ack_d) begin
        dat_q <= {16'h0000, rd_word};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      base_q <= `RFR_BASE_RST;
      intv_q <= CNT_W'(`RFR_INTV_RST);
    end else if (i_ce) begin
      if (wr_base) begin
        base_q <= i_wb_dat[15:16-BASE_W];
      end
      if (wr_intv) begin
        intv_q <= intv_d;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      en_q <= 1'b0;
      cnt_q <= CNT_W'(`RFR_CNT_RST);
      req_q <= 1'b0;
      lost_q <= 1'b0;
    end else if (i_ce) begin
      if (wr_en) begin
        en_q <= i_wb_dat[`RFR_EN_BIT];
      end
      cnt_q <= cnt_d;
      req_q <= req_d;
      lost_q <= tick & req_q & ~served;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= rfr_pkg::RFR_IDLE;
      row_q <= ROW_W'(`RFR_ROW_RST);
      cyc_q <= '{active: 1'b0, addr: 20'h00000, status: `RFR_STAT_IDLE,
                 rd_n: 1'b1, byte_high_enable_n: 1'b1};
    end else if (i_ce) begin
      st_q <= st_d;
      cyc_q <= cyc_d;
      if (served) begin
        row_q <= row_q + ROW_W'(1);
      end
    end
  end

  // Ack shows only on enabled edges, so a write never lands on a frozen one
  assign o_wb_ack = ack_q & i_ce;
  assign o_wb_dat = dat_q;
  assign o_cyc = cyc_q;
  assign o_refresh_req = req_q;
  assign o_req_lost = lost_q;

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_count_down;
    i_ce && en_q && !wr_en && cnt_q > CNT_W'(`RFR_CNT_HIT)
      |=> cnt_q == $past(cnt_q) - 1;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("interval counter did not step down");

  property p_reload;
    i_ce && en_q && !wr_en && cnt_q == CNT_W'(`RFR_CNT_HIT)
      |=> cnt_q == $past(intv_q) && req_q;
  endproperty
  a_reload: assert property (p_reload)
    else $error("no reload or request when count reached one");

  property p_base_field;
    cyc_q.active |-> cyc_q.addr[19:20-BASE_W] == base_q;
  endproperty
  a_base_field: assert property (p_base_field)
    else $error("refresh address upper bits differ from base");

  property p_wrap;
    i_ce && served && (&row_q) && !wr_base
      |=> base_q == $past(base_q) && row_q == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("row wrap disturbed the base register");

  property p_fixed_bits;
    cyc_q.active |-> cyc_q.addr[0] && cyc_q.addr[ROW_W+ZW:ROW_W+1] == '0
      && cyc_q.addr[ROW_W:1] == row_q;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("refresh address fixed or row bits wrong");

  property p_priority;
    req_q && bus_free |-> o_grant == 4'h1;
  endproperty
  a_priority: assert property (p_priority)
    else $error("refresh did not win arbitration");

  property p_dummy_read;
    i_ce && start |=> cyc_q.active && cyc_q.status == `RFR_STAT_MEMRD
      && cyc_q.rd_n;
  endproperty
  a_dummy_read: assert property (p_dummy_read)
    else $error("refresh cycle did not open as a memory read");

  property p_locked_out;
    i_ce && !i_enhanced_mode |=> $stable(intv_q) && $stable(base_q)
      && (!$past(ack_d) || o_wb_dat == 32'h0000_0000);
  endproperty
  a_locked_out: assert property (p_locked_out)
    else $error("register access outside enhanced mode");

  property p_lost;
    i_ce && tick && req_q && !served |=> lost_q && req_q;
  endproperty
  a_lost: assert property (p_lost)
    else $error("second request was queued instead of dropped");

  property p_row_served;
    i_ce && !served |=> $stable(row_q);
  endproperty
  a_row_served: assert property (p_row_served)
    else $error("row advanced without a refresh cycle");

  property p_off_clear;
    !en_q |-> cnt_q == '0;
  endproperty
  a_off_clear: assert property (p_off_clear)
    else $error("counter not clear while disabled");

  property p_read_count;
    i_ce && ack_d && hit_en && !i_wb_we && i_enhanced_mode
      |=> o_wb_dat[CNT_W-1:0] == $past(cnt_q)
      && o_wb_dat[`RFR_EN_BIT] == $past(en_q);
  endproperty
  a_read_count: assert property (p_read_count)
    else $error("enable register read lost count or enable");

  property p_req_holds;
    req_q && !served |=> req_q;
  endproperty
  a_req_holds: assert property (p_req_holds)
    else $error("refresh request dropped before service");

  property p_wide_pin;
    cyc_q.active |-> cyc_q.byte_high_enable_n == WIDE_BUS;
  endproperty
  a_wide_pin: assert property (p_wide_pin)
    else $error("byte-high pin wrong during refresh");

  property p_reset_state;
    disable iff (1'b0) !i_rst_n |=> !en_q && cnt_q == '0 && !req_q;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("unit not idle after reset");

  c_reload: cover property (i_ce && tick && en_q);
  c_served: cover property (i_ce && served);
  c_lost: cover property (lost_q);
  c_wrap: cover property (i_ce && served && (&row_q));

endmodule

// ### bench/rfr_mem_model.sv
`timescale 1ns/1ps
module rfr_mem_model (
  // Clock
  input wire logic i_clk,
  // Refresh cycle seen on the memory interface
  input wire rfr_pkg::rfr_cyc_t i_cyc,
  // Wait-state answer
  output logic o_ready
);
  logic [1:0] wait_q;
  wire data_ph = i_cyc.active & ~i_cyc.rd_n;

  // Treated like any memory read; ready comes after 0 to 3 waits
  assign o_ready = data_ph & (wait_q == 2'h0);

  always @(posedge i_clk) begin
    if (!data_ph)
      wait_q <= 2'($urandom % 4);
    else if (wait_q != 2'h0)
      wait_q <= wait_q - 2'h1;
  end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
`include "rfr_map.svh"
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, enh = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, busy = 1'b0, rdy;
  logic [2:0] oth = 3'h0;
  logic [3:0] sel = 4'h0, grant, g_exp;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0, rdat;
  logic [15:0] q;
  logic ack, req, lost;
  rfr_pkg::rfr_cyc_t cyc_o;
  int n_errors = 0, checked = 0, nref = 0, row = 0, base, intv, n;
  bit rnd = 0, act_p = 0;

  rfr_refresh_unit i_rfr_refresh_unit (.i_clk(clk), .i_rst_n(rst_n),
    .i_ce(ce), .i_enhanced_mode(enh), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_cpu_req(oth[0]),
    .i_dma_req(oth[1]), .i_hold_req(oth[2]), .i_bus_busy(busy),
    .o_grant(grant), .i_mem_ready(rdy), .o_cyc(cyc_o),
    .o_refresh_req(req), .o_req_lost(lost));

  rfr_mem_model i_rfr_mem_model (.i_clk(clk), .i_cyc(cyc_o), .o_ready(rdy));

  initial forever #20 clk = ~clk;

  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    sel <= 4'h3;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      chk("ack", 1, {31'h0, ack});
      give_verdict();
    end
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [15:0] e, string nm);
    wb(1'b0, a, 16'h0);
    chk(nm, {16'h0, e}, {16'h0, q});
  endtask

  task automatic wait_lost(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (lost !== 1'b1 && c < 400);
    if (lost !== 1'b1) begin
      chk("lost", 1, {31'h0, lost});
      give_verdict();
    end
  endtask

  // Random bus traffic, plus grant and refresh address reference model
  always @(posedge clk) begin
    if (rnd) begin
      oth <= 3'($urandom);
      busy <= ($urandom % 8) == 0;
      ce <= ($urandom % 8) != 0;
    end
    if (busy || cyc_o.active)
      g_exp = 4'h0;
    else if (req)
      g_exp = 4'h1;
    else if (oth[2])
      g_exp = 4'h2;
    else if (oth[1])
      g_exp = 4'h4;
    else if (oth[0])
      g_exp = 4'h8;
    else
      g_exp = 4'h0;
    if (rst_n)
      chk("grant", {28'h0, g_exp}, {28'h0, grant});
    if (rst_n && cyc_o.active && !act_p) begin
      chk("addr", {base[6:0], 3'h0, row[8:0], 1'b1}, cyc_o.addr);
      chk("status", `RFR_STAT_MEMRD, cyc_o.status);
      chk("byte_high", 1, cyc_o.byte_high_enable_n);
      row = (row + 1) % 512;
      nref++;
    end
    act_p = cyc_o.active;
  end

  initial begin
    n = $urandom(90015);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk("req", 0, req);
    rdc(`RFR_ADR(`RFR_IDX_ENCNT), 16'h0, "encnt");
    enh <= 1'b0;
    wb(1'b1, `RFR_ADR(`RFR_IDX_INTV), 16'h0055);
    rdc(`RFR_ADR(`RFR_IDX_INTV), 16'h0, "intv off");
    enh <= 1'b1;
    rdc(`RFR_ADR(`RFR_IDX_INTV), 16'h0, "intv");
    rdc(12'h3fc, 16'h0, "unmapped");
    base = $urandom % 128;
    intv = 18 + $urandom % 24;
    wb(1'b1, `RFR_ADR(`RFR_IDX_BASE), 16'(base << 9));
    wb(1'b1, `RFR_ADR(`RFR_IDX_INTV), 16'(intv));
    rdc(`RFR_ADR(`RFR_IDX_BASE), 16'(base << 9), "base");
    rdc(`RFR_ADR(`RFR_IDX_INTV), 16'(intv), "intv");
    busy <= 1'b1;
    wb(1'b1, `RFR_ADR(`RFR_IDX_ENCNT), 16'h8000);
    wb(1'b0, `RFR_ADR(`RFR_IDX_ENCNT), 16'h0);
    n = (q[15] === 1'b1 && q[8:0] <= intv && q[8:0] != 0);
    chk("live", 1, n);
    wait_lost(n);
    wait_lost(n);
    chk("period", intv - 1, n);
    chk("req held", 1, req);
    rnd = 1;
    n = 0;
    while (nref < 514 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    chk("refreshes", 1, 32'(nref >= 514));
    rnd = 0;
    @(posedge clk);
    ce <= 1'b1;
    busy <= 1'b1;
    wb(1'b1, `RFR_ADR(`RFR_IDX_ENCNT), 16'h0);
    rdc(`RFR_ADR(`RFR_IDX_ENCNT), 16'h0, "encnt off");
    give_verdict();
  end
endmodule
